//--- design/haptic_regs_params.svh
`ifndef HAPTIC_REGS_PARAMS_SVH
`define HAPTIC_REGS_PARAMS_SVH

// ****************************************
// register offsets (page zero)
// ****************************************
`define OFS_STATUS 8'h00
`define OFS_CONFIG 8'h01
`define OFS_CONTROL 8'h02
`define OFS_SLOT_FIRST 8'h03
`define OFS_SLOT_EIGHT 8'h0A
`define OFS_STREAM_ENTRY 8'h0B
`define OFS_PAGE_SELECT 8'hFF

// ****************************************
// field positions and reset values
// ****************************************
`define CONTROL_GO_BIT 0
`define STATUS_BUSY_BIT 0
`define REG_RESET 8'h00
`define PAGE_CONTROL 8'h00
`define SLOT_END_ID 8'h00

// ****************************************
// sequencer and memory sizing
// ****************************************
`define SLOT_COUNT 8
`define SLOT_LAST 3'h7
`define MEM_PAGES 8
`define MEM_BYTES 2048

// ****************************************
// serial port
// ****************************************
`define DEV_ADDR_DEFAULT 7'h5A
`define BITS_PER_BYTE 4'h8

`endif

//--- design/haptic_regs_pkg.sv
package haptic_regs_pkg;

	// ****************************************
	// sequencer states
	// ****************************************
	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b001,
		SEQ_FETCH = 3'b010,
		SEQ_PLAY = 3'b100
	} seq_state_e;

	// ****************************************
	// serial port states
	// ****************************************
	typedef enum logic [7:0] {
		SP_IDLE = 8'b0000_0001,
		SP_ADDR = 8'b0000_0010,
		SP_ACK_ADDR = 8'b0000_0100,
		SP_REG = 8'b0000_1000,
		SP_ACK_WR = 8'b0001_0000,
		SP_WDATA = 8'b0010_0000,
		SP_RDATA = 8'b0100_0000,
		SP_ACK_RD = 8'b1000_0000
	} sp_state_e;

	typedef logic [7:0] byte_t;

endpackage : haptic_regs_pkg

//--- design/serial_reg_port.sv
`timescale 1ns/100ps
`include "haptic_regs_params.svh"

module serial_reg_port #(
	parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT // arbitrary value
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// serial pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// register access
	output haptic_regs_pkg::byte_t reg_addr_o,
	output haptic_regs_pkg::byte_t reg_wdata_o,
	output logic reg_wr_o,
	input wire haptic_regs_pkg::byte_t reg_rdata_i
);
	import haptic_regs_pkg::*;

	typedef struct packed {
		logic [2:0] scl_sync;
		logic [2:0] sda_sync;
		logic scl_f;
		logic sda_f;
		sp_state_e state;
		logic [3:0] bitcnt;
		byte_t shreg;
		logic rw;
		byte_t ptr;
		byte_t wdata;
		logic wr;
		logic oe;
	} port_s;

	port_s q;
	port_s d;
	logic scl_new;
	logic sda_new;
	logic rise;
	logic fall;
	logic full;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		d = q;
		d.wr = 1'b0;
		d.scl_sync = {q.scl_sync[1:0], scl_i};
		d.sda_sync = {q.sda_sync[1:0], sda_i};
		// glitch filter: change counts once second and third stage agree
		scl_new = (q.scl_sync[1] == q.scl_sync[2]) ? q.scl_sync[2] : q.scl_f;
		sda_new = (q.sda_sync[1] == q.sda_sync[2]) ? q.sda_sync[2] : q.sda_f;
		d.scl_f = scl_new;
		d.sda_f = sda_new;
		rise = ~q.scl_f & scl_new;
		fall = q.scl_f & ~scl_new;
		full = (q.bitcnt == `BITS_PER_BYTE);
		if (q.scl_f && scl_new && q.sda_f && !sda_new) begin
			d.state = SP_ADDR;
			d.bitcnt = 4'h0;
			d.oe = 1'b0;
		end else if (q.scl_f && scl_new && !q.sda_f && sda_new) begin
			d.state = SP_IDLE;
			d.oe = 1'b0;
		end else if (rise) begin
			unique case (q.state)
				SP_ADDR, SP_REG, SP_WDATA: begin
					d.shreg = {q.shreg[6:0], sda_new};
					d.bitcnt = q.bitcnt + 4'h1;
				end
				SP_ACK_RD: begin
					// master nack ends the read burst
					if (sda_new) begin
						d.state = SP_IDLE;
					end else begin
						d.ptr = q.ptr + 8'h01;
					end
				end
				default: begin
				end
			endcase
		end else if (fall) begin
			unique case (q.state)
				SP_ADDR: begin
					if (full && q.shreg[7:1] == DEV_ADDR) begin
						d.oe = 1'b1;
						d.rw = q.shreg[0];
						d.state = SP_ACK_ADDR;
					end else if (full) begin
						d.state = SP_IDLE;
					end
				end
				SP_ACK_ADDR: begin
					d.bitcnt = 4'h0;
					if (q.rw) begin
						d.shreg = reg_rdata_i;
						d.oe = ~reg_rdata_i[7];
						d.bitcnt = 4'h1;
						d.state = SP_RDATA;
					end else begin
						d.oe = 1'b0;
						d.state = SP_REG;
					end
				end
				SP_REG: begin
					if (full) begin
						d.ptr = q.shreg;
						d.oe = 1'b1;
						d.state = SP_ACK_WR;
					end
				end
				SP_WDATA: begin
					if (full) begin
						d.wr = 1'b1;
						d.wdata = q.shreg;
						d.oe = 1'b1;
						d.state = SP_ACK_WR;
					end
				end
				SP_ACK_WR: begin
					d.oe = 1'b0;
					d.bitcnt = 4'h0;
					d.state = SP_WDATA;
				end
				SP_RDATA: begin
					if (full) begin
						d.oe = 1'b0;
						d.state = SP_ACK_RD;
					end else begin
						d.shreg = {q.shreg[6:0], 1'b0};
						d.oe = ~q.shreg[6];
						d.bitcnt = q.bitcnt + 4'h1;
					end
				end
				SP_ACK_RD: begin
					d.shreg = reg_rdata_i;
					d.oe = ~reg_rdata_i[7];
					d.bitcnt = 4'h1;
					d.state = SP_RDATA;
				end
				default: begin
				end
			endcase
		end
		// pointer moves after the strobe so the bank sees the written address
		if (q.wr) begin
			d.ptr = q.ptr + 8'h01;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			q <= '{scl_sync: 3'b111, sda_sync: 3'b111, scl_f: 1'b1, sda_f: 1'b1,
				state: SP_IDLE, default: '0};
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign sda_o = 1'b0;
	assign sda_oe_o = q.oe;
	assign reg_addr_o = q.ptr;
	assign reg_wdata_o = q.wdata;
	assign reg_wr_o = q.wr;

endmodule : serial_reg_port

//--- design/waveform_sequence_and_page_regs.sv
`timescale 1ns/100ps
`include "haptic_regs_params.svh"

// Function
// - on trigger the engine reads slot 0x03 first and plays that waveform id
// - after each waveform completes the engine advances to the next slot
// - a slot holding id zero ends the sequence with nothing more played
// - the sequence ends after eight slots even without a zero id
// - every byte written to 0x0B on page zero is pushed as the next stream sample
// - register 0xFF selects the page onto which register accesses map
// - page zero is control space, pages 1 to 8 are waveform memory
// - bit 0 of register 0x02 is the trigger; writing 0x01 starts sequencing
module waveform_sequence_and_page_regs #(
	parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT // arbitrary value
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// serial pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// waveform player
	output haptic_regs_pkg::byte_t play_id_o,
	output logic play_start_o,
	input wire logic play_done_i,
	output logic seq_busy_o,
	// stream samples
	output haptic_regs_pkg::byte_t stream_data_o,
	output logic stream_push_o,
	// waveform memory read port
	input wire logic [10:0] mem_raddr_i,
	output haptic_regs_pkg::byte_t mem_rdata_o,
	// configuration bits
	output haptic_regs_pkg::byte_t config_o,
	output haptic_regs_pkg::byte_t control_o
);
	import haptic_regs_pkg::*;

	typedef struct packed {
		byte_t cfg;
		byte_t ctrl;
		logic [`SLOT_COUNT-1:0][7:0] slot;
		byte_t stream;
		byte_t page;
		seq_state_e state;
		logic [2:0] idx;
		byte_t rdata;
		byte_t play_id;
		logic play_start;
		byte_t stream_data;
		logic stream_push;
		logic rd_mem;
	} bank_s;

	bank_s q;
	bank_s d;
	byte_t mem [`MEM_BYTES];
	byte_t mem_rd_q;
	byte_t mem_port_q;
	byte_t addr;
	byte_t wdata;
	byte_t rdata;
	logic wr;
	logic mem_page;
	logic [10:0] mem_idx;
	logic [2:0] slot_off;
	logic go_wr;
	logic page_ctl;
	logic slot_hit;
	logic seq_idle;

	// ****************************************
	// serial front end
	// ****************************************
	serial_reg_port #(
		.DEV_ADDR(DEV_ADDR)
	) u_port (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.sda_o(sda_o),
		.sda_oe_o(sda_oe_o),
		.reg_addr_o(addr),
		.reg_wdata_o(wdata),
		.reg_wr_o(wr),
		.reg_rdata_i(rdata)
	);

	// ****************************************
	// page mapping
	// ****************************************
	// pages beyond the memory size decode to nothing; reads give zero
	assign page_ctl = (q.page == `PAGE_CONTROL);
	assign mem_page = !page_ctl && (q.page <= 8'(`MEM_PAGES));
	// byte 0xff of every page is shadowed by the page register itself
	assign mem_idx = {3'(q.page - 8'h01), addr};
	assign slot_off = 3'(addr - `OFS_SLOT_FIRST);
	assign slot_hit = (addr >= `OFS_SLOT_FIRST) && (addr <= `OFS_SLOT_EIGHT);
	assign seq_idle = (q.state == SEQ_IDLE);
	assign go_wr = wr && addr == `OFS_CONTROL && page_ctl;
	assign rdata = q.rd_mem ? mem_rd_q : q.rdata;

	// ****************************************
	// registers and sequencer
	// ****************************************
	always_comb begin
		d = q;
		d.play_start = 1'b0;
		d.stream_push = 1'b0;
		d.rd_mem = mem_page && addr != `OFS_PAGE_SELECT;
		// read mux; page select answers on every page
		d.rdata = `REG_RESET;
		if (addr == `OFS_PAGE_SELECT) begin
			d.rdata = q.page;
		end else if (page_ctl) begin
			if (addr == `OFS_STATUS) begin
				d.rdata[`STATUS_BUSY_BIT] = !seq_idle;
			end else if (addr == `OFS_CONFIG) begin
				d.rdata = q.cfg;
			end else if (addr == `OFS_CONTROL) begin
				d.rdata = q.ctrl;
			end else if (slot_hit) begin
				d.rdata = q.slot[slot_off];
			end else if (addr == `OFS_STREAM_ENTRY) begin
				d.rdata = q.stream;
			end
		end
		// sequencer
		unique case (q.state)
			SEQ_IDLE: begin
				if (q.ctrl[`CONTROL_GO_BIT]) begin
					d.idx = 3'h0;
					d.state = SEQ_FETCH;
				end
			end
			SEQ_FETCH: begin
				if (q.slot[q.idx] == `SLOT_END_ID) begin
					d.ctrl[`CONTROL_GO_BIT] = 1'b0;
					d.state = SEQ_IDLE;
				end else begin
					d.play_id = q.slot[q.idx];
					d.play_start = 1'b1;
					d.state = SEQ_PLAY;
				end
			end
			SEQ_PLAY: begin
				if (play_done_i && q.idx == `SLOT_LAST) begin
					d.ctrl[`CONTROL_GO_BIT] = 1'b0;
					d.state = SEQ_IDLE;
				end else if (play_done_i) begin
					d.idx = q.idx + 3'h1;
					d.state = SEQ_FETCH;
				end
			end
			// an upset state code falls back to idle and drops the trigger
			default: begin
				d.ctrl[`CONTROL_GO_BIT] = 1'b0;
				d.state = SEQ_IDLE;
			end
		endcase
		// clearing the trigger aborts; a host write wins over the hardware clear
		if (go_wr && !wdata[`CONTROL_GO_BIT]) begin
			// a start already decided in fetch must not leak out after the abort
			d.play_start = 1'b0;
			d.play_id = q.play_id;
			d.state = SEQ_IDLE;
		end
		if (wr) begin
			if (addr == `OFS_PAGE_SELECT) begin
				d.page = wdata;
			end else if (page_ctl) begin
				if (addr == `OFS_CONFIG) begin
					d.cfg = wdata;
				end else if (addr == `OFS_CONTROL) begin
					d.ctrl = wdata;
				end else if (slot_hit) begin
					d.slot[slot_off] = wdata;
				end else if (addr == `OFS_STREAM_ENTRY) begin
					// no buffer here: the consumer takes each sample on its pulse
					d.stream = wdata;
					d.stream_data = wdata;
					d.stream_push = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			q <= '{state: SEQ_IDLE, default: '0};
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// waveform memory
	// ****************************************
	// no reset on the array: contents are undefined until the host loads them
	always_ff @(posedge core_clk_i) begin
		if (wr && mem_page && addr != `OFS_PAGE_SELECT) begin
			mem[mem_idx] <= wdata;
		end
		mem_rd_q <= mem[mem_idx];
		mem_port_q <= mem[mem_raddr_i];
	end

	// ****************************************
	// outputs
	// ****************************************
	assign play_id_o = q.play_id;
	assign play_start_o = q.play_start;
	assign seq_busy_o = !seq_idle;
	assign stream_data_o = q.stream_data;
	assign stream_push_o = q.stream_push;
	assign mem_rdata_o = mem_port_q;
	assign config_o = q.cfg;
	assign control_o = q.ctrl;

endmodule : waveform_sequence_and_page_regs

//--- test/waveform_sequence_and_page_regs_checker.sv
`timescale 1ns/100ps
module waveform_sequence_and_page_regs_checker (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// watched ports
	input wire haptic_regs_pkg::byte_t play_id_o,
	input wire logic play_start_o,
	input wire logic seq_busy_o,
	input wire logic stream_push_o,
	input wire haptic_regs_pkg::byte_t control_o
);
	// starts seen in the current sequence
	logic [3:0] starts_q;
	logic [3:0] starts_d;
	always_comb begin
		starts_d = seq_busy_o ? starts_q + {3'b000, play_start_o} : 4'h0;
	end
	always_ff @(posedge core_clk_i) begin
		starts_q <= rst_n_i ? starts_d : 4'h0;
	end
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	chk_idle_no_start: assert property (!seq_busy_o |=> !play_start_o)
		else $error("start while idle");
	chk_go_to_fetch: assert property ($rose(control_o[0]) && !seq_busy_o |=>
		seq_busy_o ##1 (play_start_o || !seq_busy_o)) else $error("trigger not taken");
	chk_id_hold: assert property (!play_start_o |-> $stable(play_id_o))
		else $error("id moved without start");
	chk_start_gap: assert property (play_start_o |=> !play_start_o [*2])
		else $error("starts too close");
	chk_start_nonzero: assert property (play_start_o |-> play_id_o != 8'h00)
		else $error("zero id played");
	chk_eight_max: assert property (starts_q <= 4'h8)
		else $error("more than eight starts");
	chk_push_pulse: assert property (stream_push_o |=> !stream_push_o)
		else $error("push longer than one cycle");
	chk_go_cleared: assert property ($fell(seq_busy_o) |-> ##[0:1] !control_o[0])
		else $error("go bit left set");
endmodule : waveform_sequence_and_page_regs_checker

bind waveform_sequence_and_page_regs waveform_sequence_and_page_regs_checker i_chk (
	.core_clk_i(core_clk_i),
	.rst_n_i(rst_n_i),
	.play_id_o(play_id_o),
	.play_start_o(play_start_o),
	.seq_busy_o(seq_busy_o),
	.stream_push_o(stream_push_o),
	.control_o(control_o)
);

//--- test/i2c_host_model.sv
`timescale 1ns/100ps
`include "haptic_regs_params.svh"
module i2c_host_model (
	// clock
	input wire logic core_clk_i,
	// serial pins, sda released when high
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	int ack_err = 0;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// slow phases: the port filters edges closer than two cycles
	task automatic half;
		repeat (6) @(posedge core_clk_i);
	endtask : half
	task automatic bit_x(input logic b, output logic r);
		sda_o <= b;
		half();
		scl_o <= 1'b1;
		half();
		r = sda_i;
		scl_o <= 1'b0;
		half();
	endtask : bit_x
	task automatic start;
		sda_o <= 1'b1;
		half();
		scl_o <= 1'b1;
		half();
		sda_o <= 1'b0;
		half();
		scl_o <= 1'b0;
		half();
	endtask : start
	task automatic put(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r);
		end
		bit_x(1'b1, r);
		if (r !== 1'b0) begin
			ack_err++;
		end
	endtask : put
	task automatic addr_ptr(input logic [7:0] p);
		start();
		put({`DEV_ADDR_DEFAULT, 1'b0});
		put(p);
	endtask : addr_ptr
	task automatic stop;
		sda_o <= 1'b0;
		half();
		scl_o <= 1'b1;
		half();
		sda_o <= 1'b1;
		half();
	endtask : stop
	task automatic write_reg(input logic [7:0] p, input logic [7:0] d);
		addr_ptr(p);
		put(d);
		stop();
	endtask : write_reg
	task automatic read_reg(input logic [7:0] p, output logic [7:0] q);
		logic r;
		addr_ptr(p);
		start();
		put({`DEV_ADDR_DEFAULT, 1'b1});
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, r);
			q[i] = r;
		end
		bit_x(1'b1, r);
		stop();
	endtask : read_reg
endmodule : i2c_host_model

//--- test/waveform_sequence_and_page_regs_bench.sv
`timescale 1ns/100ps
module waveform_sequence_and_page_regs_bench;
	import haptic_regs_pkg::*;
	// ****************
	// signals
	// ****************
	logic core_clk_i;
	logic rst_n_i;
	logic play_done_i = 1'b0;
	logic [10:0] mem_raddr_i = 11'h000;
	logic scl_w, sda_host, sda_line, sda_o_w, sda_oe_w, start_w, busy_w, push_w;
	byte_t id_w, sdata_w, mdata_w, ctl_w, cfg_w, rd, lf = 8'h40;
	byte_t slots[8];
	byte_t ofs[3] = '{8'h0A, 8'h0B, 8'hFF};
	byte_t exp_q[$], str_q[$];
	int error_cnt = 0, checks_done = 0, w;
	// pull-up on the shared data line
	assign sda_line = sda_host & ~(sda_oe_w & ~sda_o_w);
	i2c_host_model i_host (.core_clk_i(core_clk_i), .sda_i(sda_line), .scl_o(scl_w),
		.sda_o(sda_host));
	waveform_sequence_and_page_regs i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.scl_i(scl_w), .sda_i(sda_line), .sda_o(sda_o_w), .sda_oe_o(sda_oe_w),
		.play_id_o(id_w), .play_start_o(start_w), .play_done_i(play_done_i),
		.seq_busy_o(busy_w), .stream_data_o(sdata_w), .stream_push_o(push_w),
		.mem_raddr_i(mem_raddr_i), .mem_rdata_o(mdata_w), .config_o(cfg_w), .control_o(ctl_w));
	function automatic byte_t lfsr_next(input byte_t s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr_next
	task automatic cmp(input byte_t got, input byte_t exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrap_up
	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end
	initial begin
		repeat (60000) @(posedge core_clk_i);
		error_cnt++;
		wrap_up();
	end
	// player answers after a varying delay
	initial begin
		forever begin
			@(posedge core_clk_i);
			if (start_w === 1'b1) begin
				cmp(id_w, exp_q.size() ? exp_q.pop_front() : 8'h00);
				repeat (1 + lf[1:0]) @(posedge core_clk_i);
				play_done_i <= 1'b1;
				@(posedge core_clk_i);
				play_done_i <= 1'b0;
			end
		end
	end
	always @(posedge core_clk_i) begin
		if (push_w === 1'b1) begin
			cmp(sdata_w, str_q.size() ? str_q.pop_front() : 8'h00);
		end
	end
	// ****************
	// main sequence
	// ****************
	initial begin
		rst_n_i = 1'b0;
		repeat (2) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		repeat (8) @(posedge core_clk_i);
		foreach (ofs[i]) begin
			i_host.read_reg(ofs[i], rd);
			cmp(rd, 8'h00);
		end
		// config register reads back and shows on its pins
		lf = lfsr_next(lf);
		i_host.write_reg(8'h01, lf);
		cmp(cfg_w, lf);
		i_host.read_reg(8'h01, rd);
		cmp(rd, lf);
		cmp(ctl_w, 8'h00);
		repeat (3) begin
			lf = lfsr_next(lf);
			str_q.push_back(lf);
			i_host.write_reg(8'h0B, lf);
		end
		i_host.read_reg(8'h0B, rd);
		cmp(rd, lf);
		cmp(8'(str_q.size()), 8'h00);
		for (int p = 1; p < 3; p++) begin
			i_host.write_reg(8'hFF, 8'(p));
			i_host.read_reg(8'hFF, rd);
			cmp(rd, 8'(p));
			i_host.write_reg(8'h0A, 8'(p * 8'h11));
			i_host.read_reg(8'h0A, rd);
			cmp(rd, 8'(p * 8'h11));
		end
		// a page past the memory takes no writes and reads as zero
		i_host.write_reg(8'hFF, 8'h09);
		i_host.write_reg(8'h0A, 8'h55);
		i_host.read_reg(8'h0A, rd);
		cmp(rd, 8'h00);
		i_host.write_reg(8'hFF, 8'h00);
		i_host.read_reg(8'h0A, rd);
		cmp(rd, 8'h00);
		for (int p = 1; p < 3; p++) begin
			mem_raddr_i <= {3'(p - 1), 8'h0A};
			repeat (2) @(posedge core_clk_i);
			cmp(mdata_w, 8'(p * 8'h11));
		end
		// second run ends early on a zero slot
		for (int r = 0; r < 2; r++) begin
			for (int i = 0; i < 8; i++) begin
				lf = lfsr_next(lf);
				slots[i] = (r == 1 && i == 2) ? 8'h00 : (lf | 8'h01);
				i_host.write_reg(8'h03 + 8'(i), slots[i]);
			end
			for (int i = 0; i < 8 && slots[i] != 8'h00; i++) begin
				exp_q.push_back(slots[i]);
			end
			i_host.write_reg(8'h02, 8'h01);
			w = 0;
			while (busy_w === 1'b1 && w < 4000) begin
				@(posedge core_clk_i);
				w++;
			end
			// a sequence that never ends shows as busy still high
			cmp(8'(busy_w), 8'h00);
			cmp(8'(exp_q.size()), 8'h00);
			i_host.read_reg(8'h02, rd);
			cmp(rd & 8'h01, 8'h00);
			i_host.read_reg(8'h00, rd);
			cmp(rd, 8'h00);
		end
		cmp(8'(i_host.ack_err), 8'h00);
		wrap_up();
	end
endmodule : waveform_sequence_and_page_regs_bench
